// File: verilog/lpms_pkg.sv
// Package of constants and types for the low-power mode sequencer.
// Assumes a single 125 MHz reference clock that also stands in for the oscillator clock.
package lpms_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS     = 8;
    localparam logic [6:0]  FLUSH_DIV_LOW     = 7'h10;
    localparam logic [6:0]  FLUSH_DIV_MID     = 7'h20;
    localparam logic [6:0]  FLUSH_DIV_HIGH    = 7'h40;
    localparam logic [5:0]  CLKOUT_LOW_DELAY  = 6'h24;
    localparam int unsigned LOCK_CYCLES       = 131072;
    localparam logic [10:0] RESUME_FLASH      = 11'h464;
    localparam logic [10:0] RESUME_SRAM       = 11'h020;
    localparam logic [3:0]  WAKE_LATENCY      = 4'h8;
    localparam logic [3:0]  IRQ_FETCH_LATENCY = 4'hA;
    localparam logic [10:0] OSC_STABLE_CYCLES = 11'h400;

    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0] MODE_IDLE    = 2'h0;
    localparam logic [1:0] MODE_STANDBY = 2'h1;
    localparam logic [1:0] MODE_HALT    = 2'h2;

    typedef enum logic [3:0] {
        LPMS_RUN, LPMS_FLUSH, LPMS_IDLE, LPMS_STANDBY, LPMS_WAKE_LAT, LPMS_HALT,
        LPMS_OSC_WAIT, LPMS_LOCK, LPMS_RESUME
    } lpms_state_type;
endpackage

// File: verilog/lpms_if.sv
// Interface between the sequencer and its cycle counter.
// Assumes both ends run on the same clock.
interface lpms_cnt_if;
    logic        load;
    logic [17:0] value;
    logic        done;
    modport ctrl (output load, output value, input done);
    modport cnt  (input load, input value, output done);
endinterface

// File: verilog/lpms_counter.sv
// Down counter that signals when a loaded count has elapsed.
// Assumes load is a one-cycle pulse from the sequencer.
module lpms_counter
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // Control
    lpms_cnt_if.cnt   cnt
);
    logic [17:0] count_r;
    logic [17:0] count_nxt;
    logic        done_r;
    logic        done_nxt;

    always_comb
    begin
        count_nxt = count_r;
        done_nxt  = 1'b0;
        if (cnt.load)
            count_nxt = cnt.value;
        else if (count_r != 18'h00000)
        begin
            count_nxt = count_r - 18'h00001;
            done_nxt  = (count_r == 18'h00001);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            count_r <= 18'h00000;
            done_r  <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign cnt.done = done_r;
endmodule

// File: verilog/lpms_top.sv
// Low-power mode sequencer: IDLE, STANDBY and HALT entry and exit.
// Assumes the core pulses i_idle_exec when it executes the idle instruction.
// What this block does
// - Holds the system clock for 16, 32 or 64 cycles by divider select before stopping it.
// - In standby, gates peripheral clocks but keeps PLL and watchdog running.
// - A standby wake leaves the mode after a latency and raises the interrupt only if enabled.
// - In halt, stops peripheral and core clocks and PLL, and the oscillator for crystal sources.
// - A falling wake pin during halt sets a flag with no clock; the oscillator restarts once the reference clock has synchronised it.
// - After oscillator stability, counts 131072 oscillator cycles even with the PLL disabled.
// - At lock end, enables core and peripheral clocks, leaves halt and serves an enabled interrupt.
// - Resumes execution within 1125 cycles from flash or 35 from SRAM after lock.
// - Drives the clock output low 32 to 45 cycles after the idle instruction in standby and halt, not in idle.
// - Fetches the interrupt vector within the qualifier window plus 12 cycles.
module lpms_top
(
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // Core requests and configuration
    input  wire logic       i_idle_exec,
    input  wire logic [1:0] i_lpm_select,
    input  wire logic [1:0] i_clock_divider_select,
    input  wire logic       i_crystal_source,
    input  wire logic       i_run_from_flash,
    input  wire logic       i_wake_int_enable,
    // Wake sources from pins
    input  wire logic       i_wake_standby,
    input  wire logic       i_wake_gpio_n,
    input  wire logic       i_ext_int,
    // Clock gates and status
    output logic            o_system_clock_en,
    output logic            o_periph_clock_en,
    output logic            o_core_clock_en,
    output logic            o_pll_en,
    output logic            o_osc_en,
    output logic            o_watchdog_en,
    output logic            o_external_clock_output_en,
    output logic            o_resume,
    output logic            o_wake_irq,
    output logic            o_vector_fetch
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Bit 0 is the standby wake pin, bit 1 the interrupt pin, bit 2 the halt wake flag.
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] sync1_nxt;
    logic       int_prev_r;
    logic       wake_edge_r;
    logic       in_halt_r;
    logic       wake_arm_n;

    always_comb
    begin
        sync1_nxt = {wake_edge_r, i_ext_int, i_wake_standby};
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1_r    <= 3'h0;
            sync2_r    <= 3'h0;
            int_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r    <= sync1_nxt;
            sync2_r    <= sync1_r;
            int_prev_r <= sync2_r[1];
        end
    end

    // The falling edge sets the flag with no clock; it is held clear outside halt so no stale edge ends a halt.
    assign wake_arm_n = i_rstn & in_halt_r;
    always_ff @(negedge i_wake_gpio_n or negedge wake_arm_n)
    begin
        if (!wake_arm_n)
            wake_edge_r <= 1'b0;
        else
            wake_edge_r <= 1'b1;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    lpms_cnt_if cnt_bus ();
    lpms_counter u_counter
    (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .cnt       (cnt_bus)
    );

    lpms_pkg::lpms_state_type state_r, state_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic [5:0]  clkout_cnt_r, clkout_cnt_nxt;
    logic        clkout_en_r, clkout_en_nxt;
    logic        sys_en_r, sys_en_nxt;
    logic        per_en_r, per_en_nxt;
    logic        core_en_r, core_en_nxt;
    logic        pll_en_r, pll_en_nxt;
    logic        osc_en_r, osc_en_nxt;
    logic        resume_r, resume_nxt;
    logic        irq_r, irq_nxt;
    logic        halt_nxt;
    logic        wdog_en_r, wdog_en_nxt;
    logic        load;
    logic [17:0] load_val;

    assign cnt_bus.load  = load;
    assign cnt_bus.value = load_val;

    always_comb
    begin
        state_nxt      = state_r;
        mode_nxt       = mode_r;
        sys_en_nxt     = sys_en_r;
        per_en_nxt     = per_en_r;
        core_en_nxt    = core_en_r;
        pll_en_nxt     = pll_en_r;
        osc_en_nxt     = osc_en_r;
        resume_nxt     = 1'b0;
        irq_nxt        = 1'b0;
        halt_nxt       = in_halt_r;
        load           = 1'b0;
        load_val       = 18'h00000;
        clkout_cnt_nxt = clkout_cnt_r;
        clkout_en_nxt  = clkout_en_r;
        if (clkout_cnt_r != 6'h00)
        begin
            clkout_cnt_nxt = clkout_cnt_r - 6'h01;
            if (clkout_cnt_r == 6'h01)
                clkout_en_nxt = 1'b0;
        end
        case (state_r)
            lpms_pkg::LPMS_RUN:
                if (i_idle_exec)
                begin
                    mode_nxt = i_lpm_select;
                    if (i_lpm_select == lpms_pkg::MODE_IDLE)
                        state_nxt = lpms_pkg::LPMS_IDLE;
                    else
                    begin
                        state_nxt      = lpms_pkg::LPMS_FLUSH;
                        load           = 1'b1;
                        load_val       = {11'h000, (i_clock_divider_select == 2'h3) ? lpms_pkg::FLUSH_DIV_HIGH
                                                 : (i_clock_divider_select == 2'h2) ? lpms_pkg::FLUSH_DIV_MID
                                                 : lpms_pkg::FLUSH_DIV_LOW};
                        clkout_cnt_nxt = lpms_pkg::CLKOUT_LOW_DELAY;
                    end
                end
            lpms_pkg::LPMS_IDLE:
                if (sync2_r[0])
                begin
                    state_nxt  = lpms_pkg::LPMS_RUN;
                    resume_nxt = 1'b1;
                    irq_nxt    = i_wake_int_enable;
                end
            lpms_pkg::LPMS_FLUSH:
                if (cnt_bus.done)
                begin
                    sys_en_nxt = 1'b0;
                    per_en_nxt = 1'b0;
                    if (mode_r == lpms_pkg::MODE_HALT)
                    begin
                        core_en_nxt = 1'b0;
                        pll_en_nxt  = 1'b0;
                        osc_en_nxt  = !i_crystal_source;
                        halt_nxt    = 1'b1;
                        state_nxt   = lpms_pkg::LPMS_HALT;
                    end
                    else
                        state_nxt = lpms_pkg::LPMS_STANDBY;
                end
            lpms_pkg::LPMS_STANDBY:
                if (sync2_r[0])
                begin
                    state_nxt = lpms_pkg::LPMS_WAKE_LAT;
                    load      = 1'b1;
                    load_val  = {14'h0000, lpms_pkg::WAKE_LATENCY};
                end
            lpms_pkg::LPMS_WAKE_LAT:
                if (cnt_bus.done)
                begin
                    sys_en_nxt    = 1'b1;
                    per_en_nxt    = 1'b1;
                    clkout_en_nxt = 1'b1;
                    resume_nxt    = 1'b1;
                    irq_nxt       = i_wake_int_enable;
                    state_nxt     = lpms_pkg::LPMS_RUN;
                end
            lpms_pkg::LPMS_HALT:
                if (sync2_r[2])
                begin
                    osc_en_nxt = 1'b1;
                    halt_nxt   = 1'b0;
                    state_nxt  = lpms_pkg::LPMS_OSC_WAIT;
                    load       = 1'b1;
                    load_val   = {7'h00, lpms_pkg::OSC_STABLE_CYCLES};
                end
            lpms_pkg::LPMS_OSC_WAIT:
                if (cnt_bus.done)
                begin
                    pll_en_nxt = 1'b1;
                    state_nxt  = lpms_pkg::LPMS_LOCK;
                    load       = 1'b1;
                    load_val   = 18'(lpms_pkg::LOCK_CYCLES);
                end
            lpms_pkg::LPMS_LOCK:
                if (cnt_bus.done)
                begin
                    sys_en_nxt    = 1'b1;
                    per_en_nxt    = 1'b1;
                    core_en_nxt   = 1'b1;
                    clkout_en_nxt = 1'b1;
                    state_nxt     = lpms_pkg::LPMS_RESUME;
                    load          = 1'b1;
                    load_val      = {7'h00, i_run_from_flash ? lpms_pkg::RESUME_FLASH : lpms_pkg::RESUME_SRAM};
                end
            lpms_pkg::LPMS_RESUME:
                if (cnt_bus.done)
                begin
                    resume_nxt = 1'b1;
                    irq_nxt    = i_wake_int_enable;
                    state_nxt  = lpms_pkg::LPMS_RUN;
                end
            default:
                state_nxt = lpms_pkg::LPMS_RUN;
        endcase
        wdog_en_nxt = pll_en_nxt | !halt_nxt;
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_r      <= lpms_pkg::LPMS_RUN;
            mode_r       <= lpms_pkg::MODE_IDLE;
            sys_en_r     <= 1'b1;
            per_en_r     <= 1'b1;
            core_en_r    <= 1'b1;
            pll_en_r     <= 1'b1;
            osc_en_r     <= 1'b1;
            resume_r     <= 1'b0;
            irq_r        <= 1'b0;
            in_halt_r    <= 1'b0;
            clkout_cnt_r <= 6'h00;
            clkout_en_r  <= 1'b1;
            wdog_en_r    <= 1'b1;
        end
        else
        begin
            state_r      <= state_nxt;
            mode_r       <= mode_nxt;
            sys_en_r     <= sys_en_nxt;
            per_en_r     <= per_en_nxt;
            core_en_r    <= core_en_nxt;
            pll_en_r     <= pll_en_nxt;
            osc_en_r     <= osc_en_nxt;
            resume_r     <= resume_nxt;
            irq_r        <= irq_nxt;
            in_halt_r    <= halt_nxt;
            clkout_cnt_r <= clkout_cnt_nxt;
            clkout_en_r  <= clkout_en_nxt;
            wdog_en_r    <= wdog_en_nxt;
        end
    end

    // ----------------------------------------
    // External interrupt to vector fetch
    // ----------------------------------------
    // A second level change before the fetch restarts the wait rather than queueing a second fetch.
    lpms_cnt_if fetch_bus ();
    lpms_counter u_fetch_counter
    (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .cnt       (fetch_bus)
    );
    assign fetch_bus.load  = sync2_r[1] != int_prev_r;
    assign fetch_bus.value = {14'h0000, lpms_pkg::IRQ_FETCH_LATENCY};

    assign o_system_clock_en          = sys_en_r;
    assign o_periph_clock_en          = per_en_r;
    assign o_core_clock_en            = core_en_r;
    assign o_pll_en                   = pll_en_r;
    assign o_osc_en                   = osc_en_r;
    assign o_watchdog_en              = wdog_en_r;
    assign o_external_clock_output_en = clkout_en_r;
    assign o_resume                   = resume_r;
    assign o_wake_irq                 = irq_r;
    assign o_vector_fetch             = fetch_bus.done;
endmodule

// File: dv/lpms_chk.sv
// Port timing checker for the low-power mode sequencer.
// Assumes it is bound to lpms_top and sees only that module's ports.
module lpms_chk
(
    // Clock, reset and requests
    input wire logic       i_ref_clk,
    input wire logic       i_rstn,
    input wire logic       i_idle_exec,
    input wire logic [1:0] i_lpm_select,
    input wire logic [1:0] i_clock_divider_select,
    input wire logic       i_crystal_source,
    input wire logic       i_run_from_flash,
    input wire logic       i_wake_int_enable,
    input wire logic       i_wake_standby,
    input wire logic       i_wake_gpio_n,
    input wire logic       i_ext_int,
    // Watched outputs
    input wire logic       o_system_clock_en,
    input wire logic       o_periph_clock_en,
    input wire logic       o_core_clock_en,
    input wire logic       o_pll_en,
    input wire logic       o_osc_en,
    input wire logic       o_watchdog_en,
    input wire logic       o_external_clock_output_en,
    input wire logic       o_resume,
    input wire logic       o_wake_irq,
    input wire logic       o_vector_fetch
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // Halt dwell counter
    // --------------------------------
    logic [19:0] lock_cnt_r;
    logic [19:0] lock_cnt_nxt;
    logic        halt_seen_r;
    logic        halt_seen_nxt;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // The count spans the whole oscillator-on dwell, so it can only overstate the lock wait.
    always_comb
    begin
        lock_cnt_nxt = o_core_clock_en ? 20'h00000 : lock_cnt_r + {19'h00000, o_osc_en};
        halt_seen_nxt = !o_core_clock_en && (halt_seen_r || !o_pll_en);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lock_cnt_r <= 20'h00000;
            halt_seen_r <= 1'b0;
        end
        else
        begin
            lock_cnt_r <= lock_cnt_nxt;
            halt_seen_r <= halt_seen_nxt;
        end
    end

    a_flush_long: assert property (i_idle_exec && i_lpm_select != 2'h0 && i_clock_divider_select == 2'h3
        |-> ##63 o_system_clock_en ##[1:3] !o_system_clock_en) else $error("flush length wrong");
    a_clkout_window: assert property (i_idle_exec && i_lpm_select != 2'h0
        |-> ##31 o_external_clock_output_en ##[1:14] !o_external_clock_output_en) else $error("clock out late");
    a_standby_keeps: assert property ($fell(o_periph_clock_en) && i_lpm_select == 2'h1
        |-> o_pll_en && o_watchdog_en) else $error("standby stopped pll");
    a_halt_off: assert property ($fell(o_periph_clock_en) && i_lpm_select == 2'h2
        |-> ##[0:2] (!o_pll_en && !o_core_clock_en && o_osc_en != i_crystal_source)) else $error("halt gating");
    a_gpio_restart: assert property ($fell(i_wake_gpio_n) && !o_osc_en |-> ##[1:6] o_osc_en)
        else $error("oscillator not restarted");
    a_standby_exit: assert property ($rose(i_wake_standby) && !o_periph_clock_en && i_lpm_select == 2'h1
        |-> ##[8:14] o_resume) else $error("standby exit late");
    a_irq_gated: assert property (o_wake_irq |-> i_wake_int_enable) else $error("irq while disabled");
    a_lock_wait: assert property ($rose(o_core_clock_en) && halt_seen_r |-> lock_cnt_r > 20'h20000)
        else $error("lock wait short");
    a_sram_resume: assert property ($rose(o_core_clock_en) && halt_seen_r && !i_run_from_flash
        |-> ##[0:35] o_resume) else $error("resume late");
    a_vector_fetch: assert property ($changed(i_ext_int) |-> ##[1:14] o_vector_fetch)
        else $error("vector fetch late");

    c_standby: cover property ($rose(i_wake_standby) && !o_periph_clock_en);
    c_halt_wake: cover property ($fell(i_wake_gpio_n) && !o_pll_en);
    c_vector: cover property (o_vector_fetch);
endmodule

bind lpms_top lpms_chk lpms_chk_i (.i_ref_clk, .i_rstn, .i_idle_exec, .i_lpm_select, .i_clock_divider_select,
    .i_crystal_source, .i_run_from_flash, .i_wake_int_enable, .i_wake_standby, .i_wake_gpio_n, .i_ext_int,
    .o_system_clock_en, .o_periph_clock_en, .o_core_clock_en, .o_pll_en, .o_osc_en, .o_watchdog_en,
    .o_external_clock_output_en, .o_resume, .o_wake_irq, .o_vector_fetch);

// File: dv/lpms_wake_src.sv
// Model of the external wake source and its oscillator timing duties.
// Assumes the bench raises a request level and the idle pulse is visible.
module lpms_wake_src
#(
    parameter int OSC_HOLD = lpms_pkg::OSC_STABLE_CYCLES + 2
)
(
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    // Watched lines and bench requests
    input  wire logic i_idle_exec,
    input  wire logic i_osc_en,
    input  wire logic i_go_standby,
    input  wire logic i_go_halt,
    // Wake pins
    output logic      o_wake_standby,
    output logic      o_wake_gpio_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int since_idle;
    int osc_cnt;

    always @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            since_idle <= 0;
            osc_cnt <= 0;
            o_wake_standby <= 1'b0;
            o_wake_gpio_n <= 1'b1;
        end
        else
        begin
            since_idle <= i_idle_exec ? 0 : since_idle + 1;
            osc_cnt <= (o_wake_gpio_n || !i_osc_en) ? 0 : osc_cnt + 1;
            o_wake_standby <= i_go_standby && since_idle >= 4;
            if (i_go_halt && since_idle >= 4 && o_wake_gpio_n)
                o_wake_gpio_n <= 1'b0;
            // Releasing early would feed the lock phase an unsettled clock.
            if (osc_cnt > OSC_HOLD)
                o_wake_gpio_n <= 1'b1;
        end
    end
endmodule

// File: dv/testbench.sv
// Self-checking bench for the low-power mode sequencer.
// Assumes the package constants and a 125 MHz reference clock.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       i_ref_clk = 1'b0;
    logic       i_rstn = 1'b0;
    logic       i_idle_exec = 1'b0;
    logic [1:0] i_lpm_select = 2'h0;
    logic [1:0] i_clock_divider_select = 2'h0;
    logic       i_crystal_source = 1'b0;
    logic       i_run_from_flash = 1'b0;
    logic       i_wake_int_enable = 1'b0;
    logic       i_ext_int = 1'b0;
    logic       go_standby = 1'b0;
    logic       go_halt = 1'b0;
    logic       wake_standby, wake_gpio_n, sys_en, per_en, core_en, pll_en, osc_en, wdog_en;
    logic       clkout_en, resume, wake_irq, vec_fetch;
    logic [15:0] seed = 16'h816B;
    int         error_cnt = 0;
    int         check_count = 0;

    lpms_top lpms_top_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_idle_exec(i_idle_exec),
        .i_lpm_select(i_lpm_select), .i_clock_divider_select(i_clock_divider_select),
        .i_crystal_source(i_crystal_source), .i_run_from_flash(i_run_from_flash),
        .i_wake_int_enable(i_wake_int_enable), .i_wake_standby(wake_standby), .i_wake_gpio_n(wake_gpio_n),
        .i_ext_int(i_ext_int), .o_system_clock_en(sys_en), .o_periph_clock_en(per_en),
        .o_core_clock_en(core_en), .o_pll_en(pll_en), .o_osc_en(osc_en), .o_watchdog_en(wdog_en),
        .o_external_clock_output_en(clkout_en), .o_resume(resume), .o_wake_irq(wake_irq),
        .o_vector_fetch(vec_fetch));
    lpms_wake_src lpms_wake_src_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_idle_exec(i_idle_exec),
        .i_osc_en(osc_en), .i_go_standby(go_standby), .i_go_halt(go_halt),
        .o_wake_standby(wake_standby), .o_wake_gpio_n(wake_gpio_n));

    initial
    begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end

    // --------------------------------
    // Shared tasks and model
    // --------------------------------
    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic int flush_len(input int div);
        return div < 2 ? 16 : (div == 2 ? 32 : 64);
    endfunction

    task automatic enter(input logic [1:0] mode, input logic [1:0] div);
        int n, ns, nc;
        ns = 0;
        nc = 0;
        i_lpm_select = mode;
        i_clock_divider_select = div;
        // The bench never has an external memory access outstanding when the idle pulse is given.
        i_idle_exec = 1'b1;
        tick();
        i_idle_exec = 1'b0;
        for (n = 1; n < 100; n++)
        begin
            tick();
            if (ns == 0 && sys_en === 1'b0)
                ns = n;
            if (nc == 0 && clkout_en === 1'b0)
                nc = n;
        end
        if (mode == 2'h0)
            check(sys_en, 1'b1);
        else
        begin
            check(ns, flush_len(div) + 1);
            check(nc >= 32 && nc <= 45, 1'b1);
        end
        if (mode == 2'h1)
            check({per_en, pll_en, wdog_en}, 3'h3);
        if (mode == 2'h2)
            check({per_en, core_en, pll_en, osc_en, wdog_en}, {3'h0, !i_crystal_source, 1'b0});
    endtask

    task automatic wake(input logic halt, input int lat);
        int n, t_core;
        logic irq;
        irq = 1'b0;
        t_core = 0;
        go_halt = halt;
        go_standby = !halt;
        for (n = 0; n < 140000 && resume !== 1'b1; n++)
        begin
            tick();
            irq = irq | wake_irq;
            if (wake_gpio_n === 1'b0)
                go_halt = 1'b0;
            if (halt && t_core == 0 && core_en === 1'b1)
                t_core = n;
        end
        go_standby = 1'b0;
        repeat (20)
        begin
            tick();
            irq = irq | wake_irq;
        end
        check(irq, i_wake_int_enable);
        check({sys_en, per_en, core_en, pll_en}, 4'hF);
        if (halt)
        begin
            check(t_core > 131072 + 1024, 1'b1);
            check(n - t_core <= 35, 1'b1);
        end
        else
            check(n >= lat + 2 && n <= lat + 8, 1'b1);
        $display("test done: halt %0d, wake took %0d cycles", halt, n);
    endtask

    task automatic ext_toggle();
        int n;
        i_ext_int = ~i_ext_int;
        for (n = 1; n < 30 && vec_fetch !== 1'b1; n++)
            tick();
        check(n <= 14, 1'b1);
        repeat (4) tick();
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        repeat (20) @(posedge i_ref_clk);
        #1;
        i_rstn = 1'b1;
        tick();
        check({sys_en, per_en, core_en, pll_en, osc_en, resume}, 6'h3E);
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            i_wake_int_enable = seed[0];
            enter(2'h1, k[1:0]);
            wake(1'b0, lpms_pkg::WAKE_LATENCY);
            repeat (seed[3:1] + 1) tick();
            ext_toggle();
        end
        enter(2'h0, seed[5:4]);
        wake(1'b0, 0);
        i_crystal_source = 1'b1;
        i_wake_int_enable = 1'b1;
        enter(2'h2, 2'h1);
        wake(1'b1, 0);
        complete_run();
    end

    // The halt wake dominates the run at about 133k cycles.
    initial
    begin
        #(200000 * 8);
        error_cnt++;
        complete_run();
    end
endmodule
